/* File: sbt_top.v */
// Scan-testable 18-bit registered bus transceiver with a snapshot FIFO.
// Assumes all pins are synchronous to clock and sampled far faster than TCK.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_defines.vh"

module sbt_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clock,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] count
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;
	assign in_ready = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rp];
	assign count = cnt;
	always @(posedge clock) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			if (push & ~pop) begin
				cnt <= cnt + 1'b1;
			end else if (pop & ~push) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule

module sbt_top (
	input wire clock,
	input wire rst_n,
	input wire [`SBT_SEC-1:0] output_enable_n,
	input wire [`SBT_SEC-1:0] transfer_way,
	input wire [`SBT_SEC-1:0] a_to_b_capture_clock,
	input wire [`SBT_SEC-1:0] b_to_a_capture_clock,
	input wire [`SBT_SEC-1:0] b_side_source_select,
	input wire [`SBT_SEC-1:0] a_side_source_select,
	input wire [`SBT_W-1:0] a_in,
	output reg [`SBT_W-1:0] a_out,
	output reg [`SBT_W-1:0] a_oe,
	input wire [`SBT_W-1:0] b_in,
	output reg [`SBT_W-1:0] b_out,
	output reg [`SBT_W-1:0] b_oe,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo,
	output reg tdo_oe,
	input wire [`SBT_AW-1:0] reg_addr,
	input wire [`SBT_DW-1:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [`SBT_DW-1:0] reg_rdata
);
	localparam [3:0] ST_TLR = 4'h0;
	localparam [3:0] ST_RTI = 4'h1;
	localparam [3:0] ST_SDS = 4'h2;
	localparam [3:0] ST_CDR = 4'h3;
	localparam [3:0] ST_SDR = 4'h4;
	localparam [3:0] ST_E1D = 4'h5;
	localparam [3:0] ST_PDR = 4'h6;
	localparam [3:0] ST_E2D = 4'h7;
	localparam [3:0] ST_UDR = 4'h8;
	localparam [3:0] ST_SIS = 4'h9;
	localparam [3:0] ST_CIR = 4'hA;
	localparam [3:0] ST_SIR = 4'hB;
	localparam [3:0] ST_E1I = 4'hC;
	localparam [3:0] ST_PIR = 4'hD;
	localparam [3:0] ST_E2I = 4'hE;
	localparam [3:0] ST_UIR = 4'hF;

	function [1:0] dr_sel;
		input [`SBT_IR_W-1:0] op;
		begin
			case (op)
				`SBT_OP_EXTEST, `SBT_OP_SAMPLE, `SBT_OP_RUNT: dr_sel = `SBT_DR_BSR;
				`SBT_OP_SCANBCR: dr_sel = `SBT_DR_BCR;
				`SBT_OP_IDCODE: dr_sel = `SBT_DR_ID;
				default: dr_sel = `SBT_DR_BYP;
			endcase
		end
	endfunction

	function [`SBT_PW-1:0] lfsr;
		input [`SBT_PW-1:0] v;
		begin
			lfsr = {v[`SBT_PW-2:0], 1'b0} ^ (v[`SBT_PW-1] ? `SBT_LFSR_TAPS : {`SBT_PW{1'b0}});
		end
	endfunction

	reg tck_q;
	reg [3:0] tap;
	reg [3:0] next_tap;
	reg [`SBT_IR_W-1:0] ir;
	reg [`SBT_IR_W-1:0] ir_sh;
	reg [`SBT_BSR_W-1:0] bsr;
	reg [`SBT_BSR_W-1:0] upd;
	reg [`SBT_BCR_W-1:0] bcr;
	reg [`SBT_BCR_W-1:0] bcr_sh;
	reg byp;
	reg [`SBT_ID_W-1:0] id_sh;
	reg [`SBT_W-1:0] a_store;
	reg [`SBT_W-1:0] b_store;
	reg [`SBT_SEC-1:0] ab_q;
	reg [`SBT_SEC-1:0] ba_q;
	reg snap_pend;
	reg [`SBT_PW-1:0] snap_word;
	reg auto_snap;
	wire tck_rise;
	wire tck_fall;
	wire [1:0] sel;
	wire test_mode;
	wire [`SBT_SEC*6-1:0] ctl_pins;
	wire [`SBT_W-1:0] norm_a;
	wire [`SBT_W-1:0] norm_b;
	wire [`SBT_W-1:0] norm_aoe;
	wire [`SBT_W-1:0] norm_boe;
	wire [`SBT_W-1:0] test_aoe;
	wire [`SBT_W-1:0] test_boe;
	wire snap_set;
	wire fifo_ready;
	wire fifo_valid;
	wire fifo_pop;
	wire [`SBT_PW-1:0] fifo_data;
	wire [`SBT_FIFO_AW:0] fifo_count;

	assign tck_rise = tck & ~tck_q;
	assign tck_fall = ~tck & tck_q;
	assign sel = dr_sel(ir);
	assign test_mode = (ir == `SBT_OP_EXTEST) | (ir == `SBT_OP_CLAMP) |
		(ir == `SBT_OP_HIGHZ) | (ir == `SBT_OP_RUNT);
	assign ctl_pins = {output_enable_n, transfer_way, a_to_b_capture_clock,
		b_to_a_capture_clock, b_side_source_select, a_side_source_select};

	genvar s;
	generate
		for (s = 0; s < `SBT_SEC; s = s + 1) begin : g_sec
			wire en;
			wire ab_rise;
			wire ba_rise;
			assign en = ~output_enable_n[s];
			assign ab_rise = a_to_b_capture_clock[s] & ~ab_q[s];
			assign ba_rise = b_to_a_capture_clock[s] & ~ba_q[s];
			assign norm_boe[s*`SBT_SW +: `SBT_SW] = {`SBT_SW{en & transfer_way[s]}};
			assign norm_aoe[s*`SBT_SW +: `SBT_SW] = {`SBT_SW{en & ~transfer_way[s]}};
			assign norm_b[s*`SBT_SW +: `SBT_SW] = b_side_source_select[s] ?
				a_store[s*`SBT_SW +: `SBT_SW] : a_in[s*`SBT_SW +: `SBT_SW];
			assign norm_a[s*`SBT_SW +: `SBT_SW] = a_side_source_select[s] ?
				b_store[s*`SBT_SW +: `SBT_SW] : b_in[s*`SBT_SW +: `SBT_SW];
			assign test_aoe[s*`SBT_SW +: `SBT_SW] = {`SBT_SW{upd[`SBT_EN_LSB+2*s]}};
			assign test_boe[s*`SBT_SW +: `SBT_SW] = {`SBT_SW{upd[`SBT_EN_LSB+2*s+1]}};
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					ab_q[s] <= 1'b0;
					ba_q[s] <= 1'b0;
					a_store[s*`SBT_SW +: `SBT_SW] <= {`SBT_SW{1'b0}};
					b_store[s*`SBT_SW +: `SBT_SW] <= {`SBT_SW{1'b0}};
				end else begin
					ab_q[s] <= a_to_b_capture_clock[s];
					ba_q[s] <= b_to_a_capture_clock[s];
					if (ab_rise & ~test_mode) begin
						a_store[s*`SBT_SW +: `SBT_SW] <= a_in[s*`SBT_SW +: `SBT_SW];
					end
					if (ba_rise & ~test_mode) begin
						b_store[s*`SBT_SW +: `SBT_SW] <= b_in[s*`SBT_SW +: `SBT_SW];
					end
				end
			end
		end
	endgenerate

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			a_out <= {`SBT_W{1'b0}};
			b_out <= {`SBT_W{1'b0}};
			a_oe <= {`SBT_W{1'b0}};
			b_oe <= {`SBT_W{1'b0}};
		end else if (!test_mode) begin
			a_out <= norm_a;
			b_out <= norm_b;
			a_oe <= norm_aoe;
			b_oe <= norm_boe;
		end else begin
			a_out <= upd[`SBT_W-1:0];
			b_out <= upd[`SBT_PW-1:`SBT_W];
			if (ir == `SBT_OP_HIGHZ) begin
				a_oe <= {`SBT_W{1'b0}};
				b_oe <= {`SBT_W{1'b0}};
			end else begin
				a_oe <= test_aoe;
				b_oe <= test_boe;
			end
		end
	end

	always @* begin
		next_tap = tap;
		case (tap)
			ST_TLR: next_tap = tms ? ST_TLR : ST_RTI;
			ST_RTI: next_tap = tms ? ST_SDS : ST_RTI;
			ST_SDS: next_tap = tms ? ST_SIS : ST_CDR;
			ST_CDR: next_tap = tms ? ST_E1D : ST_SDR;
			ST_SDR: next_tap = tms ? ST_E1D : ST_SDR;
			ST_E1D: next_tap = tms ? ST_UDR : ST_PDR;
			ST_PDR: next_tap = tms ? ST_E2D : ST_PDR;
			ST_E2D: next_tap = tms ? ST_UDR : ST_SDR;
			ST_UDR: next_tap = tms ? ST_SDS : ST_RTI;
			ST_SIS: next_tap = tms ? ST_TLR : ST_CIR;
			ST_CIR: next_tap = tms ? ST_E1I : ST_SIR;
			ST_SIR: next_tap = tms ? ST_E1I : ST_SIR;
			ST_E1I: next_tap = tms ? ST_UIR : ST_PIR;
			ST_PIR: next_tap = tms ? ST_E2I : ST_PIR;
			ST_E2I: next_tap = tms ? ST_UIR : ST_SIR;
			ST_UIR: next_tap = tms ? ST_SDS : ST_RTI;
			default: next_tap = ST_TLR;
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tck_q <= 1'b0;
			tap <= ST_TLR;
			ir <= `SBT_OP_IDCODE;
			ir_sh <= `SBT_IR_CAPT;
			bsr <= {`SBT_BSR_W{1'b0}};
			upd <= {`SBT_BSR_W{1'b0}};
			bcr <= `SBT_BCR_RST;
			bcr_sh <= `SBT_BCR_RST;
			byp <= 1'b0;
			id_sh <= `SBT_ID_CODE;
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tck_q <= tck;
			if (tck_rise) begin
				tap <= next_tap;
				case (tap)
					ST_TLR: begin
						ir <= `SBT_OP_IDCODE;
						bcr <= `SBT_BCR_RST;
					end
					ST_RTI: begin
						if (ir == `SBT_OP_RUNT && bcr == `SBT_BCR_PSA) begin
							bsr[`SBT_PW-1:0] <= lfsr(bsr[`SBT_PW-1:0]) ^ {b_in, a_in};
						end else if (ir == `SBT_OP_RUNT && bcr == `SBT_BCR_OUTPUT_PATTERN_GENERATOR) begin
							upd[`SBT_PW-1:0] <= lfsr(upd[`SBT_PW-1:0]);
						end
					end
					ST_CIR: ir_sh <= `SBT_IR_CAPT;
					ST_SIR: ir_sh <= {tdi, ir_sh[`SBT_IR_W-1:1]};
					ST_UIR: ir <= ir_sh;
					ST_CDR: begin
						case (sel)
							`SBT_DR_BSR: bsr <= {upd[`SBT_BSR_W-1:`SBT_EN_LSB], ctl_pins, b_in, a_in};
							`SBT_DR_BCR: bcr_sh <= bcr;
							`SBT_DR_BYP: byp <= 1'b0;
							default: id_sh <= `SBT_ID_CODE;
						endcase
					end
					ST_SDR: begin
						case (sel)
							`SBT_DR_BSR: bsr <= {tdi, bsr[`SBT_BSR_W-1:1]};
							`SBT_DR_BCR: bcr_sh <= {tdi, bcr_sh[`SBT_BCR_W-1:1]};
							`SBT_DR_BYP: byp <= tdi;
							default: id_sh <= {tdi, id_sh[`SBT_ID_W-1:1]};
						endcase
					end
					ST_UDR: begin
						if (sel == `SBT_DR_BSR && ir != `SBT_OP_SAMPLE) begin
							upd <= bsr;
						end else if (sel == `SBT_DR_BSR) begin
							upd <= bsr;
						end
						if (sel == `SBT_DR_BCR) begin
							bcr <= bcr_sh;
						end
					end
					default: begin
					end
				endcase
			end
			if (tck_fall) begin
				tdo_oe <= (tap == ST_SDR) | (tap == ST_SIR);
				if (tap == ST_SIR) begin
					tdo <= ir_sh[0];
				end else begin
					case (sel)
						`SBT_DR_BSR: tdo <= bsr[0];
						`SBT_DR_BCR: tdo <= bcr_sh[0];
						`SBT_DR_BYP: tdo <= byp;
						default: tdo <= id_sh[0];
					endcase
				end
			end
		end
	end

	assign snap_set = (tck_rise & (tap == ST_CDR) & (ir == `SBT_OP_SAMPLE) & auto_snap) |
		(reg_write & (reg_addr == `SBT_ADR_CTRL) & reg_wdata[`SBT_CTRL_SNAP]);
	assign fifo_pop = reg_read & (reg_addr == `SBT_ADR_DHI);

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			snap_pend <= 1'b0;
			snap_word <= {`SBT_PW{1'b0}};
			auto_snap <= 1'b0;
			reg_rdata <= {`SBT_DW{1'b0}};
		end else begin
			snap_pend <= snap_set | (snap_pend & ~fifo_ready);
			if (snap_set) begin
				snap_word <= {b_in, a_in};
			end
			if (reg_write && reg_addr == `SBT_ADR_CTRL) begin
				auto_snap <= reg_wdata[`SBT_CTRL_AUTO];
			end
			reg_rdata <= {`SBT_DW{1'b0}};
			if (reg_read) begin
				case (reg_addr)
					`SBT_ADR_CTRL: reg_rdata <= {30'h0, auto_snap, snap_pend};
					`SBT_ADR_STAT: reg_rdata <= {7'h0, fifo_count, test_mode, tap, bcr, ir, tdo_oe, tdo,
						fifo_valid, fifo_ready};
					`SBT_ADR_DLO: reg_rdata <= {14'h0, fifo_valid ? fifo_data[`SBT_W-1:0] : {`SBT_W{1'b0}}};
					`SBT_ADR_DHI: reg_rdata <= {14'h0, fifo_valid ? fifo_data[`SBT_PW-1:`SBT_W] : {`SBT_W{1'b0}}};
					default: reg_rdata <= {`SBT_DW{1'b0}};
				endcase
			end
		end
	end

	sbt_fifo #(
		.WIDTH(`SBT_PW),
		.DEPTH(`SBT_FIFO_DEPTH),
		.AW(`SBT_FIFO_AW)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(snap_pend),
		.in_ready(fifo_ready),
		.in_data(snap_word),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data),
		.count(fifo_count)
	);
endmodule
`default_nettype wire

/* File: sbt_defines.vh */
// Constants for the scan bus transceiver block.
// Assumes inclusion by bare name from the design file.
`ifndef SBT_DEFINES_VH
`define SBT_DEFINES_VH
`define SBT_SEC 2
`define SBT_SW 9
`define SBT_W 18
`define SBT_PW 36
`define SBT_BSR_W 52
`define SBT_CTL_LSB 36
`define SBT_EN_LSB 48
`define SBT_IR_W 8
`define SBT_BCR_W 3
`define SBT_ID_W 32
`define SBT_IR_CAPT 8'h81
`define SBT_OP_EXTEST 8'h00
`define SBT_OP_SAMPLE 8'h82
`define SBT_OP_IDCODE 8'h99
`define SBT_OP_HIGHZ 8'h06
`define SBT_OP_CLAMP 8'h87
`define SBT_OP_RUNT 8'h09
`define SBT_OP_SCANBCR 8'h0F
`define SBT_OP_BYPASS 8'hFF
`define SBT_DR_BSR 2'h0
`define SBT_DR_BCR 2'h1
`define SBT_DR_BYP 2'h2
`define SBT_DR_ID 2'h3
`define SBT_BCR_PSA 3'h0
`define SBT_BCR_OUTPUT_PATTERN_GENERATOR 3'h1
`define SBT_BCR_RST 3'h0
`define SBT_LFSR_TAPS 36'h800000C00
// Arbitrary identification value.
`define SBT_ID_CODE 32'h00001001
`define SBT_AW 4
`define SBT_DW 32
`define SBT_ADR_CTRL 4'h0
`define SBT_ADR_STAT 4'h4
`define SBT_ADR_DLO 4'h8
`define SBT_ADR_DHI 4'hC
`define SBT_CTRL_SNAP 0
`define SBT_CTRL_AUTO 1
`define SBT_FIFO_DEPTH 16
`define SBT_FIFO_AW 4
`endif

/* File: sbt_props_properties.sv */
// Checker for the transceiver pins and the register read port.
// Assumes the test port stays in reset, so the block is in normal mode.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_defines.vh"
module sbt_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] output_enable_n,
	input wire logic [1:0] transfer_way,
	input wire logic [1:0] a_to_b_capture_clock,
	input wire logic [1:0] b_to_a_capture_clock,
	input wire logic [1:0] b_side_source_select,
	input wire logic [1:0] a_side_source_select,
	input wire logic [17:0] a_in,
	input wire logic [17:0] a_out,
	input wire logic [17:0] a_oe,
	input wire logic [17:0] b_in,
	input wire logic [17:0] b_out,
	input wire logic [17:0] b_oe,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata
);
	logic [17:0] sa;
	logic [17:0] sb;
	logic [1:0] pa;
	logic [1:0] pb;
	wire [1:0] en = ~output_enable_n;
	wire [1:0] w = transfer_way;
	// Shadow copies of both storage registers.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pa <= 2'h0;
			pb <= 2'h0;
			sa <= 18'h0;
			sb <= 18'h0;
		end else begin
			pa <= a_to_b_capture_clock;
			pb <= b_to_a_capture_clock;
			for (int s = 0; s < 2; s++) begin
				if (a_to_b_capture_clock[s] && !pa[s])
					sa[s*9+:9] <= a_in[s*9+:9];
				if (b_to_a_capture_clock[s] && !pb[s])
					sb[s*9+:9] <= b_in[s*9+:9];
			end
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_ab_st;
		en[0] && w[0] && b_side_source_select[0];
	endsequence
	sequence s_ba_st;
		en[1] && !w[1] && a_side_source_select[1];
	endsequence
	a_b_drive: assert property (en[0] && w[0] |=> b_oe[8:0] == 9'h1FF && a_oe[8:0] == 9'h0)
		else $error("B side not driven");
	a_a_drive: assert property (en[1] && !w[1] |=> a_oe[17:9] == 9'h1FF && b_oe[17:9] == 9'h0)
		else $error("A side not driven");
	a_iso_off: assert property (!en[1] |=> a_oe[17:9] == 9'h0 && b_oe[17:9] == 9'h0)
		else $error("drivers on while disabled");
	a_sec_apart: assert property (output_enable_n == 2'h2 && w[0] |=> b_oe == 18'h001FF && a_oe == 18'h0)
		else $error("sections not independent");
	a_live_ab: assert property (en[0] && w[0] && !b_side_source_select[0] |=> b_out[8:0] == $past(a_in[8:0]))
		else $error("live A data wrong");
	a_stored_ab: assert property (s_ab_st |=> b_out[8:0] == $past(sa[8:0]))
		else $error("stored A data wrong");
	a_live_ba: assert property (en[1] && !w[1] && !a_side_source_select[1] |=> a_out[17:9] == $past(b_in[17:9]))
		else $error("live B data wrong");
	a_stored_ba: assert property (s_ba_st |=> a_out[17:9] == $past(sb[17:9]))
		else $error("stored B data wrong");
	a_rd_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data outside answer cycle");
endmodule
bind sbt_top sbt_props chk (.clock(clock), .rst_n(rst_n), .output_enable_n(output_enable_n),
	.transfer_way(transfer_way), .a_to_b_capture_clock(a_to_b_capture_clock),
	.b_to_a_capture_clock(b_to_a_capture_clock), .b_side_source_select(b_side_source_select),
	.a_side_source_select(a_side_source_select), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
	.b_in(b_in), .b_out(b_out), .b_oe(b_oe), .reg_read(reg_read), .reg_rdata(reg_rdata));
`default_nettype wire

/* File: sbt_bus.sv */
// Model of one far-side bus: the block's driven bits win, the rest come from the bench.
// Assumes per-bit enables, high while the block drives.
`timescale 1ns/1ps
`default_nettype none
module sbt_bus (
	input wire logic [17:0] drv,
	input wire logic [17:0] out,
	input wire logic [17:0] oe,
	output logic [17:0] pin
);
	assign pin = (oe & out) | (~oe & drv);
endmodule
`default_nettype wire

/* File: scan_registered_bus_transceiver_tb_top.sv */
// Testbench for the transceiver: pins, storage and the snapshot FIFO.
// Holds tms high so the test port stays in reset until t_tap, which walks the TAP and loads HIGHZ and SAMPLE.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_defines.vh"
module scan_registered_bus_transceiver_tb_top;
	logic clock = 1'h0, rst_n = 1'h0, tck = 1'h0, tms = 1'h1, tdi = 1'h0, rw = 1'h0, rr = 1'h0;
	logic [1:0] oen = 2'h3, way = 2'h0, abc = 2'h0, bac = 2'h0, bsel = 2'h0, asel = 2'h0;
	logic [17:0] ad = 18'h0, bd = 18'h0;
	logic [3:0] ra = 4'h0;
	logic [31:0] wd = 32'h0;
	wire [17:0] ai, ao, aoe, bi, bo, boe;
	wire [31:0] rq;
	wire tdo, tdo_oe;
	int n_errors = 0, checks = 0, cyc = 0;
	always #12.5 clock = ~clock;
	sbt_top uut (.clock(clock), .rst_n(rst_n), .output_enable_n(oen), .transfer_way(way),
		.a_to_b_capture_clock(abc), .b_to_a_capture_clock(bac), .b_side_source_select(bsel),
		.a_side_source_select(asel), .a_in(ai), .a_out(ao), .a_oe(aoe), .b_in(bi), .b_out(bo),
		.b_oe(boe), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .reg_addr(ra),
		.reg_wdata(wd), .reg_write(rw), .reg_read(rr), .reg_rdata(rq));
	sbt_bus abus (.drv(ad), .out(ao), .oe(aoe), .pin(ai));
	sbt_bus bbus (.drv(bd), .out(bo), .oe(boe), .pin(bi));
	task chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clock);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		ra <= a;
		wd <= d;
		rw <= 1'h1;
		@(posedge clock);
		rw <= 1'h0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clock);
		ra <= a;
		rr <= 1'h1;
		@(posedge clock);
		rr <= 1'h0;
		#1 chk(rq & m, e);
	endtask
	task tck_cyc(input logic m, input logic d);
		step(1);
		tms <= m;
		tdi <= d;
		step(2);
		tck <= 1'h1;
		step(2);
		tck <= 1'h0;
		step(2);
	endtask
	task ir_load(input logic [7:0] op);
		logic [7:0] v;
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h0, 1'h0);
		tck_cyc(1'h0, 1'h0);
		for (int i = 0; i < 8; i++) begin
			v[i] = tdo;
			tck_cyc(i == 7, op[i]);
		end
		chk(v, `SBT_IR_CAPT);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h0, 1'h0);
	endtask
	task t_tap;
		logic [31:0] v;
		step(1);
		oen <= 2'h3;
		asel <= 2'h0;
		bsel <= 2'h0;
		ad <= 18'h0A5A5;
		bd <= 18'h2C3C3;
		tck_cyc(1'h0, 1'h0);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h0, 1'h0);
		tck_cyc(1'h0, 1'h0);
		chk(tdo_oe, 1'h1);
		for (int i = 0; i < 32; i++) begin
			v[i] = tdo;
			tck_cyc(i == 31, 1'h0);
		end
		chk(v, `SBT_ID_CODE);
		chk(tdo_oe, 1'h0);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h0, 1'h0);
		ir_load(`SBT_OP_HIGHZ);
		step(2);
		chk({aoe, boe}, 36'h0);
		chk(ao, 18'h0);
		rd(`SBT_ADR_STAT, 32'h00080060, 32'h00080FF0);
		wr(`SBT_ADR_CTRL, 32'h2);
		ir_load(`SBT_OP_SAMPLE);
		step(2);
		chk(ao, 18'h2C3C3);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h0, 1'h0);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h1, 1'h0);
		tck_cyc(1'h0, 1'h0);
		chk(ao, 18'h2C3C3);
		rd(`SBT_ADR_DLO, 32'h0A5A5);
		rd(`SBT_ADR_DHI, 32'h2C3C3);
		$display("test scan port done");
	endtask
	task t_reset;
		rd(`SBT_ADR_STAT, 32'h991, 32'hFFF87FFF);
		rd(4'h2, 32'h0);
		rd(`SBT_ADR_DHI, 32'h0);
		$display("test reset done");
	endtask
	task t_dirs;
		logic [17:0] m, ea, eb;
		for (int k = 0; k < 8; k++) begin
			m = k[0] ? 18'h3FE00 : 18'h001FF;
			ea = (!k[2] && !k[1]) ? m : 18'h0;
			eb = (!k[2] && k[1]) ? m : 18'h0;
			oen <= k[0] ? {k[2], 1'h1} : {1'h1, k[2]};
			way <= {2{k[1]}};
			ad <= 18'h2A5C3 ^ 18'(k);
			bd <= 18'h15A3C ^ 18'(k * 3);
			step(3);
			#1 chk({aoe, boe}, {ea, eb});
			chk({ao & ea, bo & eb}, {bd & ea, ad & eb});
			step(1);
		end
		$display("test directions done");
	endtask
	task t_store;
		logic [17:0] sa, sb;
		sa = 18'h2D2B4;
		sb = 18'h0F1E3;
		oen <= 2'h3;
		ad <= sa;
		bd <= sb;
		step(2);
		abc <= 2'h3;
		bac <= 2'h3;
		tck <= 1'h1;
		step(2);
		abc <= 2'h0;
		bac <= 2'h0;
		tck <= 1'h0;
		ad <= 18'h01234;
		bd <= 18'h3ABCD;
		bsel <= 2'h3;
		asel <= 2'h3;
		oen <= 2'h2;
		way <= 2'h1;
		step(3);
		#1 chk(bo[8:0], sa[8:0]);
		chk(tdo_oe, 1'h0);
		step(1);
		oen <= 2'h1;
		way <= 2'h0;
		step(3);
		#1 chk(ao[17:9], sb[17:9]);
		step(1);
		$display("test storage done");
	endtask
	task t_fifo;
		oen <= 2'h3;
		for (int i = 0; i < 17; i++) begin
			ad <= 18'h01000 + 18'(i);
			bd <= 18'h3F000 ^ 18'(i);
			step(2);
			wr(`SBT_ADR_CTRL, 32'h1);
			step(2);
		end
		rd(`SBT_ADR_STAT, 32'h01000002, 32'h01F00003);
		rd(`SBT_ADR_CTRL, 32'h1, 32'h1);
		for (int i = 0; i < 17; i++) begin
			rd(`SBT_ADR_DLO, 32'(18'h01000 + 18'(i)));
			rd(`SBT_ADR_DHI, 32'(18'h3F000 ^ 18'(i)));
		end
		rd(`SBT_ADR_DHI, 32'h0);
		rd(`SBT_ADR_STAT, 32'h1, 32'h01F00003);
		$display("test snapshot fifo done");
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		step(3);
		rst_n <= 1'h1;
		t_reset;
		t_dirs;
		t_store;
		t_fifo;
		t_tap;
		test_done;
	end
endmodule
`default_nettype wire
